// ---- ddcjtx_defines.svh ----
// timing, field and code constants for the ddc output and link transmitter
`ifndef DDCJTX_DEFINES_SVH
`define DDCJTX_DEFINES_SVH
// ----------------------------------------
// sample word layout
// ----------------------------------------
`define DDCJTX_WORD_W 16
`define DDCJTX_DATA_W 15
`define DDCJTX_DATA_LSB 1
`define DDCJTX_FLAG_POS 0
// ----------------------------------------
// link
// ----------------------------------------
`define DDCJTX_LANES 16
`define DDCJTX_K28_5 8'hBC
`define DDCJTX_K28_0 8'h1C
`define DDCJTX_K28_3 8'h7C
`define DDCJTX_ILAS_MF 3'h4
`define DDCJTX_MF_LEN 8'h20
`define DDCJTX_EMB_LEN 8'h20
`define DDCJTX_SH_DATA 2'h1
`define DDCJTX_SH_CTRL 2'h2
// ----------------------------------------
// link mode select decoding
// ----------------------------------------
`define DDCJTX_MODE_BYP 4'h0
`define DDCJTX_MODE_D4 4'h1
`define DDCJTX_MODE_D8 4'h2
`define DDCJTX_MODE_D16 4'h3
`define DDCJTX_MODE_D32 4'h4
`define DDCJTX_MODE_64B 4'h8
`endif

// ---- ddcjtx_pkg.sv ----
// types shared by the ddc output formatter and link transmitter
package ddcjtx_pkg;
  // decimation choice implied by the link mode
  typedef enum logic [2:0] {
    DDCJTX_DEC_BYP = 3'h0,
    DDCJTX_DEC_4 = 3'h1,
    DDCJTX_DEC_8 = 3'h2,
    DDCJTX_DEC_16 = 3'h3,
    DDCJTX_DEC_32 = 3'h4
  } ddcjtx_dec_t;
  // one formatted output pair
  typedef struct packed {
    logic [15:0] i_word;
    logic [15:0] q_word;
    logic cplx;
  } ddcjtx_pair_t;
  // link state, one-hot
  typedef enum logic [3:0] {
    DDCJTX_ST_CGS = 4'h1,
    DDCJTX_ST_WAIT = 4'h2,
    DDCJTX_ST_ILAS = 4'h4,
    DDCJTX_ST_DATA = 4'h8
  } ddcjtx_state_t;
endpackage

// ---- ddcjtx_buf2.sv ----
// two-entry valid/ready buffer in the sample path
`timescale 1ns/1ps
module ddcjtx_buf2 #(
  parameter int WIDTH = 33
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_r [2]; // two flop entries
  logic [WIDTH-1:0] mem_nxt [2];
  logic wp_r, wp_nxt; // write index
  logic rp_r, rp_nxt; // read index
  logic [1:0] cnt_r, cnt_nxt; // fill level
  logic push, pop;

  // ----------------------------------------
  // handshake, full and empty are honest
  // ----------------------------------------
  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rp_r]; // flop storage, indexed
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // next state of indexes and storage
  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = in_data;
      wp_nxt = ~wp_r;
    end
    if (pop) begin
      rp_nxt = ~rp_r;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  // register only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule // ddcjtx_buf2

// ---- ddcjtx_top.sv ----
// ddc output formatter and jesd-style link transmitter front end
// Functional notes
// - sample word 16 bits: 15 data, one flag
// - in-phase data bits 15:1, first flag bit 0
// - quadrature data upper bits, second flag lsb
// - decimation derived from link mode select
// - bypass forwards real undecimated samples
// - decimate by 4, 8, 16, 32 complex
// - gain boost one doubles amplitude
// - gain boost zero gives unity gain
// - up to sixteen output lanes
// - each lane 8b/10b or 64b/66b
// - low sync starts code group synchronisation
// - 64b/66b syncs on embedded sync headers
// - 64b/66b ignores sync for link purposes
// - one device clock runs all logic
// - sysref resets multiframe or multiblock counter
// - optional fec in 64b/66b, no 64b/80b
// - no crc3, no command channel bits
// - subclass 1 only, no subclass 2
// - lane alignment within single link only
// - sync timing suits both receiver revisions
// - sync request sends k28.5 on all lanes in use
// - after sync rise, wait lmfc, four-multiframe ilas
// - scrambling forced in 64b/66b, else enable bit
`timescale 1ns/1ps
`include "ddcjtx_defines.svh"
module ddcjtx_top #(
  parameter int LANES = `DDCJTX_LANES,
  parameter logic [7:0] MF_LEN = `DDCJTX_MF_LEN
) (
  input wire logic sys_clk, // single device clock
  input wire logic rst_n,
  input wire logic [3:0] link_mode_select,
  input wire logic gain_boost,
  input wire logic scrambler_enable,
  input wire logic fec_enable,
  input wire logic [4:0] lanes_used,
  input wire logic smp_valid,
  output logic smp_ready,
  input wire logic signed [14:0] smp_i,
  input wire logic signed [14:0] smp_q,
  input wire logic overrange_flag_first,
  input wire logic overrange_flag_second,
  input wire logic sync_n,
  input wire logic sysref,
  output logic [LANES*8-1:0] lane_octet,
  output logic [LANES-1:0] lane_is_k,
  output logic [LANES-1:0] lane_active,
  output logic [1:0] sync_header,
  output logic enc_64b66b,
  output logic scramble_on,
  output logic fec_on,
  output logic nco_sync,
  output logic [2:0] dec_factor,
  output logic link_up
);
  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  // mode value picks decimation; one decode used in several places
  function automatic ddcjtx_pkg::ddcjtx_dec_t mode_dec(input logic [3:0] m);
    case (m[2:0])
      3'h1: mode_dec = ddcjtx_pkg::DDCJTX_DEC_4;
      3'h2: mode_dec = ddcjtx_pkg::DDCJTX_DEC_8;
      3'h3: mode_dec = ddcjtx_pkg::DDCJTX_DEC_16;
      3'h4: mode_dec = ddcjtx_pkg::DDCJTX_DEC_32;
      default: mode_dec = ddcjtx_pkg::DDCJTX_DEC_BYP;
    endcase
  endfunction

  ddcjtx_pkg::ddcjtx_dec_t dec_now; // decimation in force
  logic is_64b; // 64b/66b coding selected
  logic cplx; // complex output
  assign dec_now = mode_dec(link_mode_select);
  assign is_64b = (link_mode_select & `DDCJTX_MODE_64B) != 4'h0;
  assign cplx = (dec_now != ddcjtx_pkg::DDCJTX_DEC_BYP);
  assign dec_factor = dec_now;
  assign enc_64b66b = is_64b;
  assign scramble_on = is_64b | scrambler_enable;
  assign fec_on = is_64b & fec_enable; // fec only exists in 64b/66b

  // ----------------------------------------
  // input synchronisers for pins
  // ----------------------------------------
  logic sync_m_r, sync_s_r, sync_d_r; // sync_n two flops then history
  logic sref_m_r, sref_s_r, sref_d_r;
  logic sync_m_nxt, sync_s_nxt, sync_d_nxt, sref_m_nxt, sref_s_nxt, sref_d_nxt;
  always_comb begin
    sync_m_nxt = sync_n;
    sync_s_nxt = sync_m_r;
    sync_d_nxt = sync_s_r;
    sref_m_nxt = sysref;
    sref_s_nxt = sref_m_r;
    sref_d_nxt = sref_s_r;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_m_r <= 1'b1;
      sync_s_r <= 1'b1;
      sync_d_r <= 1'b1;
      sref_m_r <= 1'b0;
      sref_s_r <= 1'b0;
      sref_d_r <= 1'b0;
    end else begin
      sync_m_r <= sync_m_nxt;
      sync_s_r <= sync_s_nxt;
      sync_d_r <= sync_d_nxt;
      sref_m_r <= sref_m_nxt;
      sref_s_r <= sref_s_nxt;
      sref_d_r <= sref_d_nxt;
    end
  end
  logic sref_rise;
  assign sref_rise = sref_s_r & ~sref_d_r;
  // sync used as nco sync only outside link duty in 64b/66b
  assign nco_sync = is_64b & ~sync_s_r;

  // ----------------------------------------
  // sample formatting
  // ----------------------------------------
  // boost doubles with saturation so wrap never appears
  function automatic logic [14:0] boost(input logic [14:0] x, input logic en);
    logic [15:0] d;
    d = {x[14], x} <<< 1;
    if (!en) begin
      boost = x; // unity gain
    end else if (d[15] != d[14]) begin
      boost = d[15] ? 15'h4000 : 15'h3FFF; // clip, cf. negative image caveat
    end else begin
      boost = d[14:0];
    end
  endfunction

  ddcjtx_pkg::ddcjtx_pair_t fmt; // packed pair into buffer
  ddcjtx_pkg::ddcjtx_pair_t buf_out;
  logic buf_valid, buf_ready;
  always_comb begin
    // data and flag packed in the same word, same cycle
    fmt.i_word = {boost(smp_i, gain_boost), overrange_flag_first};
    fmt.q_word = cplx ? {boost(smp_q, gain_boost), overrange_flag_second} : 16'h0000;
    fmt.cplx = cplx;
  end

  ddcjtx_buf2 #(
    .WIDTH($bits(ddcjtx_pkg::ddcjtx_pair_t))
  ) u_buf (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(smp_valid),
    .in_ready(smp_ready),
    .in_data(fmt),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_out)
  );

  // ----------------------------------------
  // multiframe / extended multiblock counter
  // ----------------------------------------
  logic [7:0] lmfc_r, lmfc_nxt;
  logic lmfc_edge;
  always_comb begin
    // sysref restarts the count at a known phase
    if (sref_rise || lmfc_r == MF_LEN - 8'h01) begin
      lmfc_nxt = 8'h00;
    end else begin
      lmfc_nxt = lmfc_r + 8'h01;
    end
  end
  // boundary is the last count, so ilas opens on count zero
  assign lmfc_edge = (lmfc_nxt == 8'h00);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lmfc_r <= 8'h00;
    end else begin
      lmfc_r <= lmfc_nxt;
    end
  end

  // ----------------------------------------
  // link state machine
  // ----------------------------------------
  ddcjtx_pkg::ddcjtx_state_t st_r, st_nxt;
  logic [2:0] ilas_mf_r, ilas_mf_nxt; // multiframes of ilas sent
  logic sync_req;
  // low level from either receiver style is a request
  assign sync_req = ~sync_s_r & ~is_64b;
  always_comb begin
    st_nxt = st_r;
    ilas_mf_nxt = ilas_mf_r;
    case (st_r)
      ddcjtx_pkg::DDCJTX_ST_CGS: begin
        // 64b/66b needs no handshake, headers carry block lock
        if (is_64b) begin
          st_nxt = ddcjtx_pkg::DDCJTX_ST_DATA;
        end else if (sync_s_r && !sync_d_r) begin
          // only a real low-to-high edge releases; idle high after reset does not
          st_nxt = ddcjtx_pkg::DDCJTX_ST_WAIT; // sync released
        end
      end
      ddcjtx_pkg::DDCJTX_ST_WAIT: begin
        if (sync_req) begin
          st_nxt = ddcjtx_pkg::DDCJTX_ST_CGS;
        end else if (lmfc_edge) begin
          st_nxt = ddcjtx_pkg::DDCJTX_ST_ILAS;
          ilas_mf_nxt = 3'h0;
        end
      end
      ddcjtx_pkg::DDCJTX_ST_ILAS: begin
        if (sync_req) begin
          st_nxt = ddcjtx_pkg::DDCJTX_ST_CGS;
        end else if (lmfc_r == MF_LEN - 8'h01) begin
          ilas_mf_nxt = ilas_mf_r + 3'h1;
          if (ilas_mf_r == `DDCJTX_ILAS_MF - 3'h1) begin
            st_nxt = ddcjtx_pkg::DDCJTX_ST_DATA; // four multiframes done
          end
        end
      end
      ddcjtx_pkg::DDCJTX_ST_DATA: begin
        if (sync_req) begin
          st_nxt = ddcjtx_pkg::DDCJTX_ST_CGS; // re-request
        end
      end
      default: st_nxt = ddcjtx_pkg::DDCJTX_ST_CGS;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ddcjtx_pkg::DDCJTX_ST_CGS;
      ilas_mf_r <= 3'h0;
    end else begin
      st_r <= st_nxt;
      ilas_mf_r <= ilas_mf_nxt;
    end
  end
  assign link_up = (st_r == ddcjtx_pkg::DDCJTX_ST_DATA);
  // samples drain only while data flows; stall otherwise fills buffer
  assign buf_ready = link_up;

  // ----------------------------------------
  // lane octet generation
  // ----------------------------------------
  logic [LANES*8-1:0] oct_r, oct_nxt;
  logic [LANES-1:0] k_r, k_nxt, act_r, act_nxt;
  logic [1:0] sh_r, sh_nxt;
  logic [63:0] payload; // word pair repeated across lanes
  assign payload = {buf_out.i_word, buf_out.q_word, buf_out.i_word, buf_out.q_word};

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      always_comb begin
        // only the lanes in use carry traffic
        act_nxt[g] = (g < lanes_used);
        if (!act_nxt[g]) begin
          oct_nxt[g*8 +: 8] = 8'h00;
          k_nxt[g] = 1'b0;
        end else if (st_r == ddcjtx_pkg::DDCJTX_ST_CGS || st_r == ddcjtx_pkg::DDCJTX_ST_WAIT) begin
          oct_nxt[g*8 +: 8] = is_64b ? 8'h00 : `DDCJTX_K28_5; // commas on all lanes
          k_nxt[g] = ~is_64b;
        end else if (st_r == ddcjtx_pkg::DDCJTX_ST_ILAS) begin
          // multiframe marked by start and end control characters
          if (lmfc_r == 8'h00) begin
            oct_nxt[g*8 +: 8] = `DDCJTX_K28_0;
            k_nxt[g] = 1'b1;
          end else if (lmfc_r == MF_LEN - 8'h01) begin
            oct_nxt[g*8 +: 8] = `DDCJTX_K28_3;
            k_nxt[g] = 1'b1;
          end else begin
            oct_nxt[g*8 +: 8] = lmfc_r; // ramp filler, never scrambled
            k_nxt[g] = 1'b0;
          end
        end else begin
          oct_nxt[g*8 +: 8] = buf_valid ? payload[(g%8)*8 +: 8] : 8'h00;
          k_nxt[g] = 1'b0;
        end
      end
    end
  endgenerate

  always_comb begin
    // header only marks data; no crc3 or command bits inside
    sh_nxt = is_64b ? `DDCJTX_SH_DATA : 2'h0;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oct_r <= '0;
      k_r <= '0;
      act_r <= '0;
      sh_r <= 2'h0;
    end else begin
      oct_r <= oct_nxt;
      k_r <= k_nxt;
      act_r <= act_nxt;
      sh_r <= sh_nxt;
    end
  end
  assign lane_octet = oct_r;
  assign lane_is_k = k_r;
  assign lane_active = act_r;
  assign sync_header = sh_r;
endmodule // ddcjtx_top

// ---- ddcjtx_top_assertions.sv ----
// port-level checks for the ddc output and link transmitter
`timescale 1ns/1ps
module ddcjtx_top_chk #(
  parameter int LANES = 16,
  parameter logic [7:0] MF_LEN = 8'h20
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] link_mode_select,
  input wire logic scrambler_enable,
  input wire logic fec_enable,
  input wire logic [4:0] lanes_used,
  input wire logic smp_valid,
  input wire logic smp_ready,
  input wire logic sync_n,
  input wire logic [LANES*8-1:0] lane_octet,
  input wire logic [LANES-1:0] lane_is_k,
  input wire logic [LANES-1:0] lane_active,
  input wire logic [1:0] sync_header,
  input wire logic enc_64b66b,
  input wire logic scramble_on,
  input wire logic fec_on,
  input wire logic [2:0] dec_factor,
  input wire logic link_up
);
  // ----------------------------------------
  // one clock domain, so shared defaults
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // six cycles covers two sync flops, state and lane register
  a_cgs_comma: assert property ((!link_mode_select[3] && !sync_n) [*6] |-> lane_octet[7:0] == 8'hBC && lane_is_k[0] && !link_up)
    else $error("comma stream missing under sync request");
  a_dec_map: assert property (dec_factor == (link_mode_select[2:0] > 3'h4 ? 3'h0 : link_mode_select[2:0]))
    else $error("decimation not derived from link mode");
  a_enc_flag: assert property (enc_64b66b == link_mode_select[3])
    else $error("line coding flag wrong");
  a_scr_force: assert property (scramble_on == (link_mode_select[3] || scrambler_enable))
    else $error("scrambler state wrong");
  a_fec_gate: assert property (fec_on == (link_mode_select[3] && fec_enable))
    else $error("fec outside 64b/66b");
  a_hdr_64b: assert property ($past(rst_n) |-> sync_header == ($past(link_mode_select[3]) ? 2'h1 : 2'h0))
    else $error("sync header wrong");
  a_link_64b: assert property (link_mode_select[3] [*4] |-> link_up)
    else $error("64b/66b link held down");
  // no drain while the link is down, so two takes fill it
  a_ready_full: assert property ((!link_up && smp_valid && smp_ready) [*2] |=> !smp_ready)
    else $error("buffer accepted beyond two entries");
  a_active_lanes: assert property ($past(rst_n) && $stable(lanes_used) |-> 32'(lane_active) == (32'h1 << lanes_used) - 32'h1)
    else $error("active lane mask wrong");
endmodule // ddcjtx_top_chk
bind ddcjtx_top ddcjtx_top_chk #(.LANES(LANES), .MF_LEN(MF_LEN)) u_chk (.*);

// ---- ddcjtx_rx_model.sv ----
// receiving logic model: sync request, comma count and timing reference
`timescale 1ns/1ps
module ddcjtx_rx_model #(
  parameter int MF = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic slow,
  input wire logic [7:0] octet0,
  input wire logic k0,
  output logic sync_n,
  output logic sysref
);
  int lmfc; // own multiframe phase
  int commas; // consecutive commas on lane 0
  // ----------------------------------------
  // handshake; slow asks for more commas before release
  // ----------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lmfc <= 0;
      commas <= 0;
      sync_n <= 1'b1;
      sysref <= 1'b0;
    end else begin
      lmfc <= (lmfc == 4 * MF - 1) ? 0 : lmfc + 1;
      // first pulse right after reset, so both counters align before init
      sysref <= (lmfc == 0); // periodic timing reference
      commas <= (k0 && octet0 == 8'hBC) ? commas + 1 : 0;
      if (req) begin
        sync_n <= 1'b0; // low asks for code group sync
      end else if (!sync_n && commas >= (slow ? 12 : 4) && lmfc % MF == 0) begin
        sync_n <= 1'b1; // release on own multiframe edge
      end
    end
  end
endmodule // ddcjtx_rx_model

// ---- ddcjtx_top_tb.sv ----
// self-checking bench for the ddc output and link transmitter
`timescale 1ns/1ps
module ddcjtx_top_tb;
  localparam logic [7:0] MF = 8'h10; // short multiframe keeps the run brief
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] link_mode_select = 4'h1;
  logic gain_boost = 1'b0;
  logic scrambler_enable = 1'b0;
  logic fec_enable = 1'b0;
  logic [4:0] lanes_used = 5'h10;
  logic smp_valid = 1'b0;
  logic signed [14:0] smp_i = 15'h0000;
  logic signed [14:0] smp_q = 15'h0000;
  logic overrange_flag_first = 1'b0;
  logic overrange_flag_second = 1'b0;
  logic req = 1'b0;
  logic slow = 1'b0;
  logic smp_ready, sync_n, sysref, enc_64b66b, scramble_on, fec_on, nco_sync, link_up;
  logic [127:0] lane_octet;
  logic [15:0] lane_is_k;
  logic [15:0] lane_active;
  logic [1:0] sync_header;
  logic [2:0] dec_factor;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  ddcjtx_top #(.MF_LEN(MF)) dut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .link_mode_select(link_mode_select),
    .gain_boost(gain_boost),
    .scrambler_enable(scrambler_enable),
    .fec_enable(fec_enable),
    .lanes_used(lanes_used),
    .smp_valid(smp_valid),
    .smp_ready(smp_ready),
    .smp_i(smp_i),
    .smp_q(smp_q),
    .overrange_flag_first(overrange_flag_first),
    .overrange_flag_second(overrange_flag_second),
    .sync_n(sync_n),
    .sysref(sysref),
    .lane_octet(lane_octet),
    .lane_is_k(lane_is_k),
    .lane_active(lane_active),
    .sync_header(sync_header),
    .enc_64b66b(enc_64b66b),
    .scramble_on(scramble_on),
    .fec_on(fec_on),
    .nco_sync(nco_sync),
    .dec_factor(dec_factor),
    .link_up(link_up)
  );
  ddcjtx_rx_model #(.MF(16)) rx (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .slow(slow),
    .octet0(lane_octet[7:0]), .k0(lane_is_k[0]), .sync_n(sync_n), .sysref(sysref));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // hang guard, far above the few hundred cycles used
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_reset(input logic [3:0] mode);
    rst_n = 1'b0;
    link_mode_select = mode;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
  endtask
  // expected word: optional doubling with saturation, flag in lsb
  function automatic logic [15:0] word(input logic signed [14:0] d, input logic f);
    int v;
    v = gain_boost ? 2 * int'(d) : int'(d);
    if (v > 16383) v = 16383;
    if (v < -16384) v = -16384;
    return {v[14:0], f};
  endfunction
  task automatic put(input logic [14:0] di, input logic [14:0] dq, input logic fi, input logic fq);
    smp_i = di;
    smp_q = dq;
    overrange_flag_first = fi;
    overrange_flag_second = fq;
    smp_valid = 1'b1;
    @(negedge sys_clk);
  endtask
  task automatic look(input logic [14:0] di, input logic [14:0] dq, input logic fi, input logic fq);
    logic [15:0] ei;
    logic [15:0] eq;
    ei = word(di, fi);
    eq = (link_mode_select[2:0] == 3'h0) ? 16'h0000 : word(dq, fq);
    chk(lane_octet, {2{ei, eq, ei, eq}});
    @(negedge sys_clk);
  endtask
  task automatic bring_up(input logic s);
    int n;
    slow = s;
    req = 1'b1;
    @(negedge sys_clk);
    req = 1'b0;
    for (n = 0; n < 40 && lane_octet[7:0] !== 8'hBC; n++) @(negedge sys_clk);
    chk(lane_octet, {16{8'hBC}});
    chk(lane_is_k, 16'hFFFF);
    chk(link_up, 1'b0);
    for (n = 0; n < 400 && !(lane_octet[7:0] === 8'h1C && lane_is_k[0] === 1'b1); n++) @(negedge sys_clk);
    chk(n < 400, 1'b1);
    repeat (MF - 1) @(negedge sys_clk);
    chk(lane_octet[7:0], 8'h7C);
    repeat (3 * MF - 2) @(negedge sys_clk);
    chk(link_up, 1'b0);
    for (n = 0; n < 4 && link_up !== 1'b1; n++) @(negedge sys_clk);
    chk(link_up, 1'b1);
    $display("link bring-up done");
  endtask
  initial begin
    do_reset(4'h1);
    put(15'h0001, 15'h0002, 1'b0, 1'b0);
    put(15'h0003, 15'h0004, 1'b0, 1'b0);
    chk(smp_ready, 1'b0);
    smp_valid = 1'b0;
    bring_up(1'b0);
    // words held across the stall drain one per cycle, none lost
    @(negedge sys_clk);
    look(15'h0001, 15'h0002, 1'b0, 1'b0);
    look(15'h0003, 15'h0004, 1'b0, 1'b0);
    chk(smp_ready, 1'b1);
    bring_up(1'b1);
    put(15'h1234, 15'h7ABC, 1'b1, 1'b0);
    put(15'h0F0F, 15'h00FF, 1'b0, 1'b1);
    smp_valid = 1'b0;
    // first word is on the lanes one edge after its take
    look(15'h1234, 15'h7ABC, 1'b1, 1'b0);
    look(15'h0F0F, 15'h00FF, 1'b0, 1'b1);
    gain_boost = 1'b1; // first pair probes saturation, second stays in range
    put(15'h3000, 15'h4000, 1'b1, 1'b1);
    put(15'h1234, 15'h7000, 1'b0, 1'b0);
    smp_valid = 1'b0;
    look(15'h3000, 15'h4000, 1'b1, 1'b1);
    look(15'h1234, 15'h7000, 1'b0, 1'b0);
    $display("sample format done");
    do_reset(4'h0);
    bring_up(1'b0);
    put(15'h2222, 15'h5555, 1'b1, 1'b1);
    smp_valid = 1'b0;
    @(negedge sys_clk);
    look(15'h2222, 15'h5555, 1'b1, 1'b1);
    $display("bypass done");
    fec_enable = 1'b1;
    for (int m = 0; m < 16; m++) begin
      link_mode_select = 4'(m);
      #1 chk({enc_64b66b, scramble_on, fec_on, dec_factor}, {{3{m[3]}}, (m[2:0] > 4) ? 3'h0 : 3'(m)});
      @(negedge sys_clk);
    end
    scrambler_enable = 1'b1;
    link_mode_select = 4'h1;
    #1 chk(scramble_on, 1'b1);
    lanes_used = 5'h04;
    repeat (3) @(negedge sys_clk);
    chk(lane_active, 16'h000F);
    $display("mode table done");
    do_reset(4'h9);
    req = 1'b1;
    @(negedge sys_clk);
    req = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk(link_up, 1'b1);
    chk(nco_sync, 1'b1);
    chk(sync_header, 2'h1);
    $display("64b/66b link done");
    final_report();
  end
endmodule // ddcjtx_top_tb
